/* sgp_port.sv */
// Six-bit general-purpose port: control registers, pin drive and pin reads
// How it works
// R1: Six pins with direction, latch, analog, drain, slew, threshold bits; pin five has no analog bit, pin three only threshold and a fixed direction.
// R2: Direction bit one turns the pin driver off; pin acts as input.
// R3: Direction bit zero enables the driver and drives the latch value.
// R4: Pin three is input-only; its direction bit always reads one.
// R5: Level register reads sampled pins; writing it updates the output latch.
// R6: Full-mask latch writes act like level writes; latch reads return stored latch.
// R7: Level writes are read-modify-write based on the current pin levels.
// R8: Analog select blanks the digital input; digital reads return zero.
// R9: Analog select leaves digital output driving untouched.
// R10: Analog select bits reset to analog; software clears them for digital use.
// R11: Software keeps analog-input pins set to input direction.
// R12: Open-drain bit set drives low only; clear drives push-pull.
// R13: Slew bit set limits edge rate; clear selects maximum rate.
// R14: Threshold bit picks input receiver for reads and change detection.
// R15: Software changes thresholds only while peripherals are disabled.
// R16: Enabled peripheral output takes the pin from the latch; reads stay.
// R17: After reset pins drive from the latch; peripherals only via pin-select.
// R18: Analog functions connect with analog select; peripheral outputs may still drive.
// R19: Threshold bit one selects Schmitt input, zero selects TTL input.
// R20: Register bits seven and six read zero; pins occupy bits five to zero.
// R21: Registers update on the clock after a write; reset makes all pins inputs.
`timescale 1ns/1ps
module sgp_port
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register access
  input wire sgp_pkg::sgp_wr_type wr_in,
  input wire logic [sgp_pkg::SGP_SEL_W-1:0] rd_sel_in,
  output logic [sgp_pkg::SGP_REG_W-1:0] rd_data_out,
  // Pad receivers
  input wire sgp_pkg::sgp_pad_type pad_in,
  // Pin-select routing of peripheral outputs
  input wire sgp_pkg::sgp_pins_type periph_sel_in,
  input wire sgp_pkg::sgp_pins_type periph_val_in,
  // Pad drivers
  output sgp_pkg::sgp_pins_type pin_out,
  output sgp_pkg::sgp_pins_type pin_oe_out,
  output sgp_pkg::sgp_pins_type slew_limit_out,
  output sgp_pkg::sgp_pins_type analog_conn_out,
  // Selected digital input, for change detection and peripherals
  output sgp_pkg::sgp_pins_type input_level_out
);
  import sgp_pkg::*;

  sgp_state_type s_r;
  sgp_state_type s_nxt;
  sgp_pins_type cell_val;
  sgp_pins_type cell_oe;
  sgp_pins_type cell_slew;
  sgp_pins_type cell_analog;
  sgp_pins_type cell_rd;
  sgp_pins_type wr_data;
  sgp_pins_type wr_mask;
  sgp_pins_type wr_base;
  sgp_pins_type wr_impl;
  sgp_pins_type wr_merged;
  logic wr_known;

  // Reset state: all pins inputs, analog selected, latch as source
  localparam sgp_state_type SGP_STATE_RST = '{
    dir: SGP_DIR_RST,
    lat: SGP_LAT_RST,
    analog_select_bit: SGP_ANALOG_SELECT_BIT_RST,
    od: SGP_OD_RST,
    slr: SGP_SLR_RST,
    inlvl: SGP_INLVL_RST,
    level: SGP_LEVEL_RST,
    rd_data: SGP_RD_RST,
    drive: '{val: 6'h00, oe: 6'h00, slew: SGP_SLR_RST, analog: SGP_ANALOG_SELECT_BIT_RST}
  };

  // Only the pin bits of a write matter; bits seven and six are dropped
  assign wr_data = wr_in.data[SGP_PINS-1:0]; // R20
  assign wr_mask = wr_in.mask[SGP_PINS-1:0];

  // Masked merge, used by every writable register
  function automatic sgp_pins_type merge_bits
  (
    input sgp_pins_type base,
    input sgp_pins_type data,
    input sgp_pins_type mask,
    input sgp_pins_type impl
  );
    merge_bits = ((base & ~mask) | (data & mask)) & impl;
  endfunction

  // Read multiplexer; unmapped indices read zero
  function automatic sgp_pins_type read_reg
  (
    input logic [2:0] sel,
    input sgp_state_type s
  );
    case (sel)
      SGP_IDX_LEVEL:
      begin
        read_reg = s.level & SGP_LEVEL_IMPL; // R5
      end
      SGP_IDX_DIR:
      begin
        read_reg = (s.dir & SGP_DIR_IMPL) | SGP_DIR_FORCED; // R4
      end
      SGP_IDX_LATCH:
      begin
        read_reg = s.lat & SGP_LAT_IMPL; // R6
      end
      SGP_IDX_ANALOG:
      begin
        read_reg = s.analog_select_bit & SGP_ANALOG_SELECT_BIT_IMPL;
      end
      SGP_IDX_OPEN_DRAIN:
      begin
        read_reg = s.od & SGP_OD_IMPL;
      end
      SGP_IDX_SLEW:
      begin
        read_reg = s.slr & SGP_SLR_IMPL;
      end
      SGP_IDX_THRESH:
      begin
        read_reg = s.inlvl & SGP_INLVL_IMPL;
      end
      default:
      begin
        read_reg = 6'h00;
      end
    endcase
  endfunction

  // Current contents by index; the level index yields the pins as read
  function automatic sgp_pins_type reg_of
  (
    input logic [2:0] sel,
    input sgp_state_type s
  );
    case (sel)
      SGP_IDX_LEVEL:
      begin
        reg_of = s.level;
      end
      SGP_IDX_DIR:
      begin
        reg_of = s.dir;
      end
      SGP_IDX_LATCH:
      begin
        reg_of = s.lat;
      end
      SGP_IDX_ANALOG:
      begin
        reg_of = s.analog_select_bit;
      end
      SGP_IDX_OPEN_DRAIN:
      begin
        reg_of = s.od;
      end
      SGP_IDX_SLEW:
      begin
        reg_of = s.slr;
      end
      SGP_IDX_THRESH:
      begin
        reg_of = s.inlvl;
      end
      default:
      begin
        reg_of = 6'h00;
      end
    endcase
  endfunction

  // Writable bits by index; level writes land in the latch
  function automatic sgp_pins_type reg_impl
  (
    input logic [2:0] sel
  );
    case (sel)
      SGP_IDX_LEVEL:
      begin
        reg_impl = SGP_LAT_IMPL;
      end
      SGP_IDX_DIR:
      begin
        reg_impl = SGP_DIR_IMPL;
      end
      SGP_IDX_LATCH:
      begin
        reg_impl = SGP_LAT_IMPL;
      end
      SGP_IDX_ANALOG:
      begin
        reg_impl = SGP_ANALOG_SELECT_BIT_IMPL;
      end
      SGP_IDX_OPEN_DRAIN:
      begin
        reg_impl = SGP_OD_IMPL;
      end
      SGP_IDX_SLEW:
      begin
        reg_impl = SGP_SLR_IMPL;
      end
      SGP_IDX_THRESH:
      begin
        reg_impl = SGP_INLVL_IMPL;
      end
      default:
      begin
        reg_impl = 6'h00;
      end
    endcase
  endfunction

  // Listed by name so a renumbered map cannot open a hole
  function automatic logic reg_known
  (
    input logic [2:0] sel
  );
    case (sel)
      SGP_IDX_LEVEL, SGP_IDX_DIR, SGP_IDX_LATCH, SGP_IDX_ANALOG,
      SGP_IDX_OPEN_DRAIN, SGP_IDX_SLEW, SGP_IDX_THRESH:
      begin
        reg_known = 1'b1;
      end
      default:
      begin
        reg_known = 1'b0;
      end
    endcase
  endfunction

  // One merged write value serves every register; the target is picked below
  assign wr_base = reg_of(wr_in.sel, s_r); // R7
  // Bits outside a register's implemented set never change
  assign wr_impl = reg_impl(wr_in.sel);
  assign wr_merged = merge_bits(wr_base, wr_data, wr_mask, wr_impl);
  // Writes to the unmapped index are dropped
  assign wr_known = reg_known(wr_in.sel);

  // Per-pin datapath, one cell per pin
  generate
    for (genvar i = 0; i < SGP_PINS; i++)
    begin : g_pin
      sgp_pin_cell
      #(
        .INPUT_ONLY(i == SGP_INPUT_ONLY_PIN)
      )
      u_cell
      (
        .dir_in(s_r.dir[i]),
        .lat_in(s_r.lat[i]),
        .analog_select_bit_in(s_r.analog_select_bit[i]),
        .od_in(s_r.od[i]),
        .slr_in(s_r.slr[i]),
        .inlvl_in(s_r.inlvl[i]),
        .periph_sel_in(periph_sel_in[i]),
        .periph_val_in(periph_val_in[i]),
        .schmitt_in(pad_in.schmitt[i]),
        .ttl_in(pad_in.ttl[i]),
        .drv_val_out(cell_val[i]),
        .drv_oe_out(cell_oe[i]),
        .slew_out(cell_slew[i]),
        .analog_out(cell_analog[i]),
        .rd_val_out(cell_rd[i])
      ); // R1
    end
  endgenerate

  always_comb
  begin
    s_nxt = s_r;

    // Pin levels sampled every cycle through the chosen receiver
    s_nxt.level = cell_rd & SGP_LEVEL_IMPL; // R5 R14 R8

    // Register writes take effect at the next clock edge
    if (wr_in.en && wr_known) // R21
    begin
      case (wr_in.sel)
        SGP_IDX_LEVEL:
        begin
          // Base is the pins as read, so analog pins fold in as zero
          s_nxt.lat = wr_merged; // R5 R7
        end
        SGP_IDX_LATCH:
        begin
          // Full writes match a level write; partial masks keep other latch bits
          s_nxt.lat = wr_merged; // R6
        end
        SGP_IDX_DIR:
        begin
          s_nxt.dir = wr_merged | SGP_DIR_FORCED; // R2 R3 R4
        end
        SGP_IDX_ANALOG:
        begin
          s_nxt.analog_select_bit = wr_merged; // R8 R10
        end
        SGP_IDX_OPEN_DRAIN:
        begin
          s_nxt.od = wr_merged; // R12
        end
        SGP_IDX_SLEW:
        begin
          s_nxt.slr = wr_merged; // R13
        end
        SGP_IDX_THRESH:
        begin
          // A change here may glitch inputs; software must idle peripherals first
          s_nxt.inlvl = wr_merged; // R14 R19
        end
        default:
        begin
          s_nxt.lat = s_r.lat;
        end
      endcase
    end

    // Readback shows the register contents before any write in this cycle
    s_nxt.rd_data = {SGP_UPPER_ZERO, read_reg(rd_sel_in, s_r)}; // R20

    // Drivers registered so every output leaves a flip-flop
    s_nxt.drive.val = cell_val;
    s_nxt.drive.oe = cell_oe; // R2 R3 R12 R16
    s_nxt.drive.slew = cell_slew; // R13
    s_nxt.drive.analog = cell_analog; // R18
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_r <= SGP_STATE_RST; // R10 R17 R21
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rd_data_out = s_r.rd_data;
  assign pin_out = s_r.drive.val;
  assign pin_oe_out = s_r.drive.oe;
  assign slew_limit_out = s_r.drive.slew;
  assign analog_conn_out = s_r.drive.analog;
  assign input_level_out = s_r.level; // R14
endmodule

/* sgp_pkg.sv */
// Constants and types shared by the six-bit port control block
package sgp_pkg;

  // Port geometry
  localparam int SGP_PINS = 6;
  localparam int SGP_REG_W = 8;
  localparam int SGP_SEL_W = 3;
  localparam int SGP_INPUT_ONLY_PIN = 3;

  // Register indices on the register access port
  localparam logic [2:0] SGP_IDX_LEVEL = 3'h0;
  localparam logic [2:0] SGP_IDX_DIR = 3'h1;
  localparam logic [2:0] SGP_IDX_LATCH = 3'h2;
  localparam logic [2:0] SGP_IDX_ANALOG = 3'h3;
  localparam logic [2:0] SGP_IDX_OPEN_DRAIN = 3'h4;
  localparam logic [2:0] SGP_IDX_SLEW = 3'h5;
  localparam logic [2:0] SGP_IDX_THRESH = 3'h6;

  // Implemented bits of each register, pin bits 5..0
  localparam logic [5:0] SGP_LEVEL_IMPL = 6'h3F;
  localparam logic [5:0] SGP_DIR_IMPL = 6'h37;
  localparam logic [5:0] SGP_LAT_IMPL = 6'h37;
  localparam logic [5:0] SGP_ANALOG_SELECT_BIT_IMPL = 6'h17;
  localparam logic [5:0] SGP_OD_IMPL = 6'h37;
  localparam logic [5:0] SGP_SLR_IMPL = 6'h37;
  localparam logic [5:0] SGP_INLVL_IMPL = 6'h3F;

  // Direction bit of the input-only pin always reads one
  localparam logic [5:0] SGP_DIR_FORCED = 6'h08;

  // Reset values
  localparam logic [5:0] SGP_DIR_RST = 6'h3F;
  localparam logic [5:0] SGP_LAT_RST = 6'h00;
  localparam logic [5:0] SGP_ANALOG_SELECT_BIT_RST = 6'h17;
  localparam logic [5:0] SGP_OD_RST = 6'h00;
  localparam logic [5:0] SGP_SLR_RST = 6'h37;
  localparam logic [5:0] SGP_INLVL_RST = 6'h00;
  localparam logic [5:0] SGP_LEVEL_RST = 6'h00;
  localparam logic [7:0] SGP_RD_RST = 8'h00;
  localparam logic [1:0] SGP_UPPER_ZERO = 2'h0;

  typedef logic [5:0] sgp_pins_type;

  // One register write request
  typedef struct packed {
    logic en;
    logic [2:0] sel;
    logic [7:0] data;
    logic [7:0] mask;
  } sgp_wr_type;

  // Pad input receivers, one bit per pin
  typedef struct packed {
    sgp_pins_type schmitt;
    sgp_pins_type ttl;
  } sgp_pad_type;

  // Per-pin controls to the pad drivers
  typedef struct packed {
    sgp_pins_type val;
    sgp_pins_type oe;
    sgp_pins_type slew;
    sgp_pins_type analog;
  } sgp_drive_type;

  // Whole state of the port
  typedef struct packed {
    sgp_pins_type dir;
    sgp_pins_type lat;
    sgp_pins_type analog_select_bit;
    sgp_pins_type od;
    sgp_pins_type slr;
    sgp_pins_type inlvl;
    sgp_pins_type level;
    logic [7:0] rd_data;
    sgp_drive_type drive;
  } sgp_state_type;

endpackage

/* sgp_pin_cell.sv */
// One pin's output source, driver enable and input read path
`timescale 1ns/1ps
module sgp_pin_cell
#(
  parameter bit INPUT_ONLY = 1'b0
)
(
  // Pin controls
  input wire logic dir_in,
  input wire logic lat_in,
  input wire logic analog_select_bit_in,
  input wire logic od_in,
  input wire logic slr_in,
  input wire logic inlvl_in,
  // Pin-select routing
  input wire logic periph_sel_in,
  input wire logic periph_val_in,
  // Pad receivers
  input wire logic schmitt_in,
  input wire logic ttl_in,
  // Results
  output logic drv_val_out,
  output logic drv_oe_out,
  output logic slew_out,
  output logic analog_out,
  output logic rd_val_out
);
  logic src;
  logic drive_en;

  // Peripheral replaces the latch only when routed in; analog mode does not block it
  assign src = periph_sel_in ? periph_val_in : lat_in; // R16 R17 R18 R9
  // Direction one releases the driver; the input-only pin never drives
  assign drive_en = ~dir_in & ~INPUT_ONLY; // R2 R3 R4
  // Open drain sinks for a low and releases for a high
  assign drv_oe_out = drive_en & (~od_in | ~src); // R12
  assign drv_val_out = src & ~od_in; // R12 R3
  assign slew_out = slr_in; // R13
  assign analog_out = analog_select_bit_in; // R18
  // Analog mode blanks the digital input buffer
  assign rd_val_out = analog_select_bit_in ? 1'b0 : (inlvl_in ? schmitt_in : ttl_in); // R8 R14 R19
endmodule

/* sgp_props.sv */
// Assertions on the six-bit port pins and readback
`timescale 1ns/1ps
module sgp_props
(
  // Clock, reset and requests
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire sgp_pkg::sgp_wr_type wr_in,
  input wire logic [2:0] rd_sel_in,
  input wire sgp_pkg::sgp_pad_type pad_in,
  input wire sgp_pkg::sgp_pins_type periph_sel_in,
  input wire sgp_pkg::sgp_pins_type periph_val_in,
  // Design outputs
  input wire logic [7:0] rd_data_out,
  input wire sgp_pkg::sgp_pins_type pin_out,
  input wire sgp_pkg::sgp_pins_type pin_oe_out,
  input wire sgp_pkg::sgp_pins_type slew_limit_out,
  input wire sgp_pkg::sgp_pins_type analog_conn_out,
  input wire sgp_pkg::sgp_pins_type input_level_out
);
  import sgp_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Full write, then a cycle with no write to that register so the outputs settle
  sequence wr_s(logic [2:0] s);
    wr_in.en && wr_in.sel == s && wr_in.mask == 8'hFF ##1 !(wr_in.en && wr_in.sel == s);
  endsequence
  upper_zero_a: assert property (rd_data_out[7:6] == 2'h0)
    else $error("read data upper bits set");
  pin_three_a: assert property (!pin_oe_out[3])
    else $error("input-only pin driven");
  level_read_a: assert property (rd_sel_in == SGP_IDX_LEVEL |=> rd_data_out[5:0] == $past(input_level_out))
    else $error("level read differs from sampled pins");
  input_subset_a: assert property (pad_in.schmitt == pad_in.ttl |=>
    (input_level_out & ~$past(pad_in.schmitt)) == 6'h00) else $error("input reads one on a low pin");
  periph_drive_a: assert property ((pin_oe_out & $past(periph_sel_in) & (pin_out ^ $past(periph_val_in))) == 6'h00)
    else $error("peripheral value not on pin");
  dir_off_a: assert property (wr_s(SGP_IDX_DIR) |=> (pin_oe_out & $past(wr_in.data[5:0], 2)) == 6'h00)
    else $error("input pin still driven");
  slew_set_a: assert property (wr_s(SGP_IDX_SLEW) |=> slew_limit_out == ($past(wr_in.data[5:0], 2) & SGP_SLR_IMPL))
    else $error("slew control mismatch");
  analog_conn_a: assert property (wr_s(SGP_IDX_ANALOG) |=>
    analog_conn_out == ($past(wr_in.data[5:0], 2) & SGP_ANALOG_SELECT_BIT_IMPL)) else $error("analog connect mismatch");
  cover property (wr_in.en);
  cover property (|(pin_oe_out & periph_sel_in));
  cover property (|analog_conn_out ##1 ~|analog_conn_out);
endmodule

/* sgp_pads.sv */
// Pad model: wire level from our driver or the outside world
`timescale 1ns/1ps
module sgp_pads
(
  // Clock and our drive
  input wire logic clk_in,
  input wire sgp_pkg::sgp_pins_type pin_in,
  input wire sgp_pkg::sgp_pins_type oe_in,
  // Outside drive and receiver skew
  input wire sgp_pkg::sgp_pins_type ext_en_in,
  input wire sgp_pkg::sgp_pins_type ext_val_in,
  input wire sgp_pkg::sgp_pins_type skew_in,
  output sgp_pkg::sgp_pad_type pad_out
);
  import sgp_pkg::*;
  sgp_pins_type lvl;
  sgp_pins_type last_r = 6'h00;
  // Floating pins wander, so nothing may lean on a held value
  assign lvl = (oe_in & pin_in) | (~oe_in & ext_en_in & ext_val_in) | (~oe_in & ~ext_en_in & ~last_r);
  always_ff @(posedge clk_in) last_r <= lvl;
  // TTL receiver may disagree with Schmitt near threshold
  assign pad_out = '{schmitt: lvl, ttl: lvl ^ skew_in};
endmodule

/* six_bit_gpio_port_control_test.sv */
// Self-checking bench for the six-bit port
`timescale 1ns/1ps
module six_bit_gpio_port_control_test;
  import sgp_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  sgp_wr_type wr_in = '0;
  logic [2:0] rd_sel_in = 3'h0;
  logic [7:0] rd_data_out;
  sgp_pad_type pad_in;
  sgp_pins_type periph_sel_in = 6'h00;
  sgp_pins_type periph_val_in = 6'h00;
  sgp_pins_type pin_out, pin_oe_out, slew_limit_out, analog_conn_out, input_level_out;
  sgp_pins_type ext_en = 6'h3F;
  sgp_pins_type ext_val = 6'h00;
  sgp_pins_type skew = 6'h00;
  int error_cnt = 0;
  int comparisons = 0;
  always #5 clk_in = ~clk_in;
  sgp_port u_sgp_port (.clk_in, .resetn_in, .wr_in, .rd_sel_in, .rd_data_out, .pad_in, .periph_sel_in,
    .periph_val_in, .pin_out, .pin_oe_out, .slew_limit_out, .analog_conn_out, .input_level_out);
  sgp_pads u_sgp_pads (.clk_in, .pin_in(pin_out), .oe_in(pin_oe_out), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .skew_in(skew), .pad_out(pad_in));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk_in);
    wr_in <= '{en: 1'b1, sel: s, data: d, mask: m};
    @(posedge clk_in);
    wr_in.en <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [2:0] s, input logic [7:0] exp);
    @(posedge clk_in);
    rd_sel_in <= s;
    repeat (3) @(posedge clk_in);
    #1 chk(nm, exp, rd_data_out);
  endtask
  task automatic pins(input logic [7:0] oe, input logic [7:0] val);
    repeat (3) @(posedge clk_in);
    #1 chk("oe", oe, {2'h0, pin_oe_out});
    chk("val", val, {2'h0, pin_out});
  endtask
  task automatic t_reset();
    logic [7:0] rv [8] = '{8'h00, 8'h3F, 8'h00, 8'h17, 8'h00, 8'h37, 8'h00, 8'h00};
    pins(8'h00, 8'h00);
    chk("slew", 8'h37, {2'h0, slew_limit_out});
    chk("analog", 8'h17, {2'h0, analog_conn_out});
    for (int i = 0; i < 8; i++) rd("reset value", 3'(i), rv[i]);
  endtask
  task automatic t_drive();
    @(posedge clk_in);
    ext_en <= 6'h08;
    wr(SGP_IDX_DIR, 8'h00, 8'hFF);
    rd("dir", SGP_IDX_DIR, 8'h08);
    wr(SGP_IDX_LATCH, 8'hFF, 8'hFF);
    rd("latch", SGP_IDX_LATCH, 8'h37);
    pins(8'h37, 8'h37);
    wr(SGP_IDX_OPEN_DRAIN, 8'h03, 8'hFF);
    wr(SGP_IDX_LATCH, 8'h01, 8'h03);
    rd("latch", SGP_IDX_LATCH, 8'h35);
    pins(8'h36, 8'h34);
    wr(SGP_IDX_OPEN_DRAIN, 8'h00, 8'hFF);
    wr(SGP_IDX_SLEW, 8'h15, 8'hFF);
    rd("slew", SGP_IDX_SLEW, 8'h15);
    chk("slew pins", 8'h15, {2'h0, slew_limit_out});
  endtask
  task automatic t_level();
    @(posedge clk_in);
    ext_en <= 6'h3F;
    ext_val <= 6'h2A;
    skew <= 6'h3F;
    wr(SGP_IDX_DIR, 8'hFF, 8'hFF);
    wr(SGP_IDX_ANALOG, 8'h00, 8'hFF);
    rd("level ttl", SGP_IDX_LEVEL, 8'h15);
    chk("input level", 8'h15, {2'h0, input_level_out});
    wr(SGP_IDX_THRESH, 8'h3F, 8'hFF);
    rd("level schmitt", SGP_IDX_LEVEL, 8'h2A);
    wr(SGP_IDX_ANALOG, 8'hFF, 8'hFF);
    rd("level analog", SGP_IDX_LEVEL, 8'h28);
    wr(SGP_IDX_LEVEL, 8'h01, 8'h01);
    rd("latch rmw", SGP_IDX_LATCH, 8'h21);
  endtask
  task automatic t_periph();
    @(posedge clk_in);
    ext_en <= 6'h08;
    periph_sel_in <= 6'h01;
    wr(SGP_IDX_DIR, 8'h00, 8'hFF);
    pins(8'h37, 8'h20);
    @(posedge clk_in);
    periph_sel_in <= 6'h00;
    pins(8'h37, 8'h21);
    wr(SGP_IDX_DIR, 8'hFF, 8'hFF);
    pins(8'h00, 8'h21);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_drive();
    t_level();
    t_periph();
    final_report();
  end
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule
bind sgp_port sgp_props u_sgp_props (.clk_in, .resetn_in, .wr_in, .rd_sel_in, .pad_in, .periph_sel_in,
  .periph_val_in, .rd_data_out, .pin_out, .pin_oe_out, .slew_limit_out, .analog_conn_out, .input_level_out);
